//--- core/motor_wave_pkg.sv
// Register map, field positions and counts for the mode timer and waveform block
package motor_wave_pkg;
	// Register indices; byte address is four times the index
	localparam logic [12:0] IDX_MT_CTL_A   = 13'h1fa4;
	localparam logic [12:0] IDX_MT_CTL_B   = 13'h1fa5;
	localparam logic [12:0] IDX_MT_CAPTURE = 13'h1fa6;
	localparam logic [12:0] IDX_MT_CMP1    = 13'h1fa8;
	localparam logic [12:0] IDX_MT_MODE_TIMER_COMPARE_TWO    = 13'h1faa;
	localparam logic [12:0] IDX_MT_MODE_TIMER_COMPARE_THREE    = 13'h1fac;
	localparam logic [12:0] IDX_WAVE_CTL_A = 13'h1fae;
	localparam logic [12:0] IDX_WAVE_CTL_B = 13'h1faf;
	localparam logic [12:0] IDX_PATTERN    = 13'h1fb2;
	localparam logic [12:0] IDX_PWM_COUNT  = 13'h1fb4;
	localparam logic [12:0] IDX_PWM_PERIOD = 13'h1fb6;
	localparam logic [12:0] IDX_CMP_U      = 13'h1fb8;
	localparam logic [12:0] IDX_CMP_V      = 13'h1fba;
	localparam logic [12:0] IDX_CMP_W      = 13'h1fbc;
	localparam logic [12:0] IDX_DEAD_TIME  = 13'h1fbe;

	// Mode timer control A fields
	localparam int MTA_ENABLE  = 0;
	localparam int MTA_POS_RST = 1;
	localparam int MTA_SW_RST  = 2;
	localparam int MTA_OVL_RST = 3;
	localparam int MTA_T3_RST  = 4;
	localparam int MTA_CLK_LO  = 5;
	localparam logic [7:0] MTA_STORE_MASK = 8'hfb;
	// Mode timer clock select codes
	localparam logic [2:0] MT_DIV8   = 3'h0;
	localparam logic [2:0] MT_DIV16  = 3'h2;
	localparam logic [2:0] MT_DIV32  = 3'h4;
	localparam logic [2:0] MT_DIV64  = 3'h6;
	localparam logic [2:0] MT_DIV128 = 3'h1;
	// Mode timer control B fields
	localparam int MTB_POS_CAP = 1;
	localparam int MTB_SW_CAP  = 2;
	localparam int MTB_OVL_CAP = 3;
	localparam int MTB_OVF     = 5;
	localparam logic [7:0] MTB_STORE_MASK = 8'h8a;

	// Waveform control A fields
	localparam int WA_ENABLE  = 0;
	localparam int WA_CENTRE  = 1;
	localparam int WA_RATIO   = 2;
	localparam int WA_POL_LO  = 4;
	localparam int WA_POL_UP  = 5;
	localparam int WA_DUTY3   = 6;
	localparam int WA_HALF    = 7;
	// Output pattern fields
	localparam int PAT_SYNC_SRC = 6;
	localparam int PAT_TYPE     = 8;
	localparam int PAT_PWM_SYNC = 11;
	localparam int PAT_DIR      = 15;
	localparam logic [1:0] SYNC_NOW = 2'h0;
	localparam logic [1:0] SYNC_POS = 2'h1;
	localparam logic [1:0] SYNC_T1  = 2'h2;
	localparam logic [1:0] SYNC_T2  = 2'h3;

	// Dead time unit in system clock periods
	localparam int DT_UNIT_CYCLES = 8;
	// Values after reset
	localparam logic [7:0]  RST_CTL8     = 8'h00;
	localparam logic [14:0] RST_PATTERN  = 15'h0000;
	localparam logic [11:0] RST_PERIOD   = 12'h010;
	localparam logic [2:0]  RST_OUT_IDLE = 3'h7;
	// Event input bit positions
	localparam int EV_POS = 0;
	localparam int EV_T1  = 1;
	localparam int EV_T2  = 2;
	localparam int EV_T3  = 3;
	localparam int EV_OVL = 4;
endpackage : motor_wave_pkg

//--- core/motor_wave.sv
// Mode timer with capture, and three-phase PWM synthesis with dead time, on AHB-Lite
`timescale 1ns/1ns
module motor_wave (
	input  wire logic        SYS_CLK,
	input  wire logic        RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        POS_DET,
	input  wire logic        TIMER1_EVT,
	input  wire logic        TIMER2_EVT,
	input  wire logic        TIMER3_EVT,
	input  wire logic        OVERLOAD_EVT,
	output logic      [2:0]  PHASE_UPPER,
	output logic      [2:0]  PHASE_LOWER,
	output logic             PWM_INT
);
	import motor_wave_pkg::*;

	logic [4:0]  ev_s1_q, ev_s2_q, ev_s3_q, ev;
	logic        wr_q;
	logic [12:0] widx_q;
	logic        we_a, we_b, we_pat;
	logic [31:0] rdata_d;
	logic [7:0]  ctla_q, ctlb_q, wca_q, wcb_q, dtr_q;
	logic [15:0] cmp1_q, mode_timer_compare_two_q, mode_timer_compare_three_q;
	logic [11:0] period_q;
	logic [11:0] cmp_q [3];
	logic [6:0]  mt_pre_q;
	logic        mt_tick;
	logic [15:0] mt_cnt_q, cap_q;
	logic        mt_clr, mt_cap, ovf_q;
	logic [3:0]  pp_q;
	logic        pwm_tick;
	logic [11:0] pcnt_q;
	logic        dir_q, prd_end, half_end;
	logic [2:0]  rc_q, rc_lim;
	logic [14:0] pat_q;
	logic [10:0] act_q;
	logic        pend_q, src_ok, apply;
	logic [2:0]  raw, raw_q, pwm_up, pwm_lo;
	logic [8:0]  dt_q [3];

	// Pins are asynchronous: two flops, then a third for the edge
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ev_s1_q <= 5'h00;
			ev_s2_q <= 5'h00;
			ev_s3_q <= 5'h00;
		end else begin
			ev_s1_q <= {OVERLOAD_EVT, TIMER3_EVT, TIMER2_EVT, TIMER1_EVT, POS_DET};
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end
	assign ev = ev_s2_q & ~ev_s3_q;

	// Bus slave: zero wait states, read data latched in the address phase
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			wr_q      <= 1'b0;
			widx_q    <= 13'h0000;
			HRDATA    <= 32'h00000000;
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (HSEL && HTRANS[1] && HREADY) begin
				wr_q   <= HWRITE && (HADDR[31:15] == 17'h00000);
				widx_q <= HADDR[14:2];
				if (!HWRITE)
					HRDATA <= rdata_d;
			end
		end
	end
	assign we_a   = wr_q && (widx_q == IDX_MT_CTL_A);
	assign we_b   = wr_q && (widx_q == IDX_MT_CTL_B);
	assign we_pat = wr_q && (widx_q == IDX_PATTERN);

	always_comb begin
		rdata_d = 32'h00000000;
		if (HADDR[31:15] == 17'h00000) begin
			unique case (HADDR[14:2])
				IDX_MT_CTL_A:   rdata_d[7:0] = ctla_q;
				IDX_MT_CTL_B:   rdata_d[7:0] = ctlb_q | ({7'h00, ovf_q} << MTB_OVF);
				IDX_MT_CAPTURE: rdata_d[15:0] = cap_q;
				IDX_MT_CMP1:    rdata_d[15:0] = cmp1_q;
				IDX_MT_MODE_TIMER_COMPARE_TWO:    rdata_d[15:0] = mode_timer_compare_two_q;
				IDX_MT_MODE_TIMER_COMPARE_THREE:    rdata_d[15:0] = mode_timer_compare_three_q;
				IDX_WAVE_CTL_A: rdata_d[7:0] = wca_q;
				IDX_WAVE_CTL_B: rdata_d[7:0] = wcb_q;
				IDX_PATTERN:    rdata_d[15:0] = {dir_q, pat_q};
				IDX_PWM_COUNT:  rdata_d[11:0] = pcnt_q;
				IDX_PWM_PERIOD: rdata_d[11:0] = period_q;
				IDX_CMP_U:      rdata_d[11:0] = cmp_q[0];
				IDX_CMP_V:      rdata_d[11:0] = cmp_q[1];
				IDX_CMP_W:      rdata_d[11:0] = cmp_q[2];
				IDX_DEAD_TIME:  rdata_d[7:0] = {2'h0, dtr_q[5:0]};
				default:        rdata_d = 32'h00000000;
			endcase
		end
	end

	// Command bits (software reset, software capture) are not stored
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			ctla_q   <= RST_CTL8;
			ctlb_q   <= RST_CTL8;
			wca_q    <= RST_CTL8;
			wcb_q    <= RST_CTL8;
			dtr_q    <= RST_CTL8;
			cmp1_q   <= 16'h0000;
			mode_timer_compare_two_q   <= 16'h0000;
			mode_timer_compare_three_q   <= 16'h0000;
			period_q <= RST_PERIOD;
			cmp_q    <= '{default: 12'h000};
		end else if (wr_q) begin
			unique case (widx_q)
				IDX_MT_CTL_A:   ctla_q <= HWDATA[7:0] & MTA_STORE_MASK;
				IDX_MT_CTL_B:   ctlb_q <= HWDATA[7:0] & MTB_STORE_MASK;
				IDX_MT_CMP1:    cmp1_q <= HWDATA[15:0];
				IDX_MT_MODE_TIMER_COMPARE_TWO:    mode_timer_compare_two_q <= HWDATA[15:0];
				IDX_MT_MODE_TIMER_COMPARE_THREE:    mode_timer_compare_three_q <= HWDATA[15:0];
				IDX_WAVE_CTL_A: wca_q <= HWDATA[7:0];
				IDX_WAVE_CTL_B: wcb_q <= {6'h00, HWDATA[1:0]};
				IDX_PWM_PERIOD: period_q <= HWDATA[11:0];
				IDX_CMP_U:      cmp_q[0] <= HWDATA[11:0];
				IDX_CMP_V:      cmp_q[1] <= HWDATA[11:0];
				IDX_CMP_W:      cmp_q[2] <= HWDATA[11:0];
				IDX_DEAD_TIME:  dtr_q <= {2'h0, HWDATA[5:0]};
				default:        ;
			endcase
		end
	end

	// Mode timer prescaler; reserved codes never tick
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			mt_pre_q <= 7'h00;
		else
			mt_pre_q <= mt_pre_q + 7'h01;
	end
	always_comb begin
		unique case (ctla_q[MTA_CLK_LO +: 3])
			MT_DIV8:   mt_tick = &mt_pre_q[2:0];
			MT_DIV16:  mt_tick = &mt_pre_q[3:0];
			MT_DIV32:  mt_tick = &mt_pre_q[4:0];
			MT_DIV64:  mt_tick = &mt_pre_q[5:0];
			MT_DIV128: mt_tick = &mt_pre_q[6:0];
			default:   mt_tick = 1'b0;
		endcase
	end

	assign mt_clr = (we_a && HWDATA[MTA_SW_RST])
		|| (ctla_q[MTA_POS_RST] && ev[EV_POS])
		|| (ctla_q[MTA_T3_RST] && ev[EV_T3])
		|| (ctla_q[MTA_OVL_RST] && ev[EV_OVL]);
	assign mt_cap = (ctlb_q[MTB_POS_CAP] && ev[EV_POS])
		|| (we_b && HWDATA[MTB_SW_CAP])
		|| (ctlb_q[MTB_OVL_CAP] && ev[EV_OVL]);

	always_ff @(posedge SYS_CLK) begin
		if (RST)
			mt_cnt_q <= 16'h0000;
		else if (mt_clr)
			mt_cnt_q <= 16'h0000;
		else if (ctla_q[MTA_ENABLE] && mt_tick)
			mt_cnt_q <= mt_cnt_q + 16'h0001;
	end

	// Capture sees the count before a same-cycle clear
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			cap_q <= 16'h0000;
		else if (mt_cap)
			cap_q <= mt_cnt_q;
	end

	// Sticky until software reset; a software reset in the same cycle wins, as it also blocks the wrap
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			ovf_q <= 1'b0;
		else if (ctla_q[MTA_ENABLE] && mt_tick && !mt_clr && &mt_cnt_q)
			ovf_q <= 1'b1;
		else if (we_a && HWDATA[MTA_SW_RST])
			ovf_q <= 1'b0;
	end

	// PWM prescaler
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			pp_q <= 4'h0;
		else
			pp_q <= pp_q + 4'h1;
	end
	always_comb begin
		unique case (wcb_q[1:0])
			2'h0: pwm_tick = pp_q[0];
			2'h1: pwm_tick = &pp_q[1:0];
			2'h2: pwm_tick = &pp_q[2:0];
			2'h3: pwm_tick = &pp_q[3:0];
		endcase
	end

	assign prd_end = pwm_tick && (wca_q[WA_CENTRE]
		? (dir_q && pcnt_q <= 12'h001) : (pcnt_q >= period_q - 12'h001));
	// Half event on the tick that reaches the midpoint, so both halves are equal except for an odd period in edge-aligned mode
	assign half_end = pwm_tick && (wca_q[WA_CENTRE]
		? (!dir_q && pcnt_q == period_q - 12'h001)
		: (pcnt_q == {1'b0, period_q[11:1]} - 12'h001));

	// Counter held at zero while synthesis is off
	always_ff @(posedge SYS_CLK) begin
		if (RST || !wca_q[WA_ENABLE]) begin
			pcnt_q <= 12'h000;
			dir_q  <= 1'b0;
		end else if (pwm_tick) begin
			if (!wca_q[WA_CENTRE]) begin
				dir_q  <= 1'b0;
				pcnt_q <= prd_end ? 12'h000 : pcnt_q + 12'h001;
			end else if (!dir_q) begin
				dir_q  <= pcnt_q >= period_q;
				pcnt_q <= (pcnt_q >= period_q) ? period_q - 12'h001 : pcnt_q + 12'h001;
			end else begin
				dir_q  <= pcnt_q > 12'h001;
				pcnt_q <= (pcnt_q == 12'h000) ? 12'h000 : pcnt_q - 12'h001;
			end
		end
	end

	always_comb begin
		unique case (wca_q[WA_RATIO +: 2])
			2'h0: rc_lim = 3'h0;
			2'h1: rc_lim = 3'h1;
			2'h2: rc_lim = 3'h3;
			2'h3: rc_lim = 3'h7;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST || !wca_q[WA_ENABLE]) begin
			rc_q    <= 3'h0;
			PWM_INT <= 1'b0;
		end else begin
			PWM_INT <= (prd_end && rc_q >= rc_lim)
				|| (half_end && wca_q[WA_HALF] && rc_lim == 3'h0);
			if (prd_end)
				rc_q <= (rc_q >= rc_lim) ? 3'h0 : rc_q + 3'h1;
		end
	end

	// Pattern shadow and its staged copy
	always_ff @(posedge SYS_CLK) begin
		if (RST)
			pat_q <= RST_PATTERN;
		else if (we_pat)
			pat_q <= HWDATA[14:0];
	end
	always_comb begin
		unique case (pat_q[PAT_SYNC_SRC +: 2])
			SYNC_NOW: src_ok = 1'b1;
			SYNC_POS: src_ok = ev[EV_POS];
			SYNC_T1:  src_ok = ev[EV_T1];
			SYNC_T2:  src_ok = ev[EV_T2];
		endcase
	end
	assign apply = pend_q && (pat_q[PAT_PWM_SYNC] ? prd_end : src_ok);

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			pend_q <= 1'b0;
			act_q  <= RST_PATTERN[10:0];
		end else begin
			if (apply)
				act_q <= pat_q[10:0];
			// A new write keeps the request alive even in an apply cycle
			pend_q <= we_pat || (pend_q && !apply);
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_phase
			logic [11:0] duty;
			logic        on_up, on_lo;
			assign duty = wca_q[WA_DUTY3] ? cmp_q[g] : cmp_q[0];
			assign raw[g] = pcnt_q < duty;

			// Both switches off for the dead time after every edge
			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					raw_q[g] <= 1'b0;
					dt_q[g]  <= 9'h000;
				end else if (raw[g] != raw_q[g]) begin
					raw_q[g] <= raw[g];
					dt_q[g]  <= {dtr_q[5:0], 3'h0};
				end else if (dt_q[g] != 9'h000) begin
					dt_q[g] <= dt_q[g] - 9'h001;
				end
			end
			assign pwm_up[g] = raw_q[g] && dt_q[g] == 9'h000;
			assign pwm_lo[g] = !raw_q[g] && dt_q[g] == 9'h000;

			assign on_up = wca_q[WA_ENABLE] && act_q[2*g]
				&& (!act_q[PAT_TYPE + g] || pwm_up[g]);
			assign on_lo = wca_q[WA_ENABLE] && act_q[2*g+1]
				&& (!act_q[PAT_TYPE + g] || pwm_lo[g]);

			always_ff @(posedge SYS_CLK) begin
				if (RST) begin
					PHASE_UPPER[g] <= RST_OUT_IDLE[g];
					PHASE_LOWER[g] <= RST_OUT_IDLE[g];
				end else begin
					PHASE_UPPER[g] <= on_up ~^ wca_q[WA_POL_UP];
					PHASE_LOWER[g] <= on_lo ~^ wca_q[WA_POL_LO];
				end
			end

			chk_dead_gap: assert property (@(posedge SYS_CLK) disable iff (RST)
				(raw[g] != raw_q[g] && dtr_q[5:0] != 6'h00) |=> !pwm_up[g] && !pwm_lo[g])
				else $error("dead time gap missing");
		end
	endgenerate

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	chk_reserved_clock: assert property (
		(ctla_q[7:5] == 3'h3 && !mt_clr) |=> $stable(mt_cnt_q))
		else $error("mode timer counted on reserved clock");
	chk_timer_hold: assert property (!ctla_q[MTA_ENABLE] && !mt_clr |=> $stable(mt_cnt_q))
		else $error("disabled mode timer moved");
	chk_sw_clear: assert property (we_a && HWDATA[MTA_SW_RST] |=> mt_cnt_q == 16'h0000)
		else $error("software reset did not clear timer");
	chk_pos_clear: assert property (
		ctla_q[MTA_POS_RST] && ev[EV_POS] |=> mt_cnt_q == 16'h0000)
		else $error("position event did not clear timer");
	chk_t3_clear: assert property (ctla_q[MTA_T3_RST] && ev[EV_T3] |=> mt_cnt_q == 16'h0000)
		else $error("timer 3 event did not clear timer");
	chk_pos_capture: assert property (
		ctlb_q[MTB_POS_CAP] && ev[EV_POS] |=> cap_q == $past(mt_cnt_q))
		else $error("position capture wrong");
	chk_sw_capture: assert property (we_b && HWDATA[MTB_SW_CAP] |=> cap_q == $past(mt_cnt_q))
		else $error("software capture wrong");
	chk_ovl_capture: assert property (
		ctlb_q[MTB_OVL_CAP] && ev[EV_OVL] |=> cap_q == $past(mt_cnt_q))
		else $error("overload capture wrong");
	chk_pwm_div16: assert property (
		wcb_q[1:0] == 2'h3 && pwm_tick |=> (!pwm_tick || wcb_q[1:0] != 2'h3) [*8])
		else $error("PWM clock faster than divide by 16");
	chk_outputs_off: assert property (
		!wca_q[WA_ENABLE] |=> PHASE_UPPER == {3{!$past(wca_q[WA_POL_UP])}})
		else $error("phase output active while disabled");
	chk_overflow_set: assert property (
		ctla_q[MTA_ENABLE] && mt_tick && !mt_clr && mt_cnt_q == 16'hffff |=> ovf_q)
		else $error("overflow flag not set on wrap");

	cov_centre_int: cover property (wca_q[WA_CENTRE] && PWM_INT);
	cov_sync_apply: cover property (apply && pat_q[PAT_PWM_SYNC]);
	cov_capture_clear: cover property (mt_cap && mt_clr);
endmodule : motor_wave

//--- tb/motor_stage_model.sv
// Behavioural inverter stage: decodes switch drives, flags shoot-through, times U-phase gaps
`timescale 1ns/1ns
module motor_stage_model (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [2:0] upper,
	input  wire logic [2:0] lower,
	input  wire logic       up_pol,
	input  wire logic       lo_pol,
	output int              shoot_cnt,
	output int              last_gap
);
	logic [2:0] up_on;
	logic [2:0] lo_on;
	int         run;
	assign up_on = up_pol ? upper : ~upper;
	assign lo_on = lo_pol ? lower : ~lower;
	// Both switches of one leg on would short the supply rail
	always @(posedge clk) begin
		if (rst) begin
			shoot_cnt <= 0;
			last_gap <= 0;
			run <= 0;
		end else begin
			if ((up_on & lo_on) != 3'h0)
				shoot_cnt <= shoot_cnt + 1;
			if (!up_on[0] && !lo_on[0])
				run <= run + 1;
			else begin
				run <= 0;
				if (run > 0)
					last_gap <= run;
			end
		end
	end
endmodule : motor_stage_model

//--- tb/motor_mode_timer_pwm_waveform_tb.sv
// Self-checking bench for the mode timer and three-phase waveform block
`timescale 1ns/1ns
module motor_mode_timer_pwm_waveform_tb;
	import motor_wave_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [4:0]  ev = 5'h0;
	logic        up_pol = 1'b0;
	logic        lo_pol = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        pwm_int;
	logic [2:0]  up;
	logic [2:0]  lo;
	logic [31:0] d;
	logic [31:0] d2;
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          shoot;
	int          gap_u;
	int          g;
	int          k;
	int          e;
	int          dtv;
	logic [12:0] ridx [4] = '{IDX_MT_CTL_A, IDX_MT_CTL_B, IDX_PATTERN, IDX_PWM_PERIOD};
	logic [31:0] rexp [4] = '{32'h0, 32'h0, 32'h0, {20'h0, RST_PERIOD}};
	logic [2:0]  codes [5] = '{MT_DIV8, MT_DIV16, MT_DIV32, MT_DIV64, MT_DIV128};
	logic [7:0]  ev_a [4] = '{8'h03, 8'h11, 8'h09, 8'h01};
	logic [7:0]  ev_b [4] = '{8'h02, 8'h00, 8'h08, 8'h00};
	int          ev_n [4] = '{EV_POS, EV_T3, EV_OVL, EV_POS};
	logic [7:0]  md_a [8] = '{8'h31, 8'h35, 8'h39, 8'h3d, 8'h33, 8'hb1, 8'hb3, 8'hb5};
	int          md_g [8] = '{32, 64, 128, 256, 64, 16, 32, 64};

	always #50 clk = ~clk;

	motor_wave dut_u (
		.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .POS_DET(ev[EV_POS]),
		.TIMER1_EVT(ev[EV_T1]), .TIMER2_EVT(ev[EV_T2]), .TIMER3_EVT(ev[EV_T3]),
		.OVERLOAD_EVT(ev[EV_OVL]), .PHASE_UPPER(up), .PHASE_LOWER(lo), .PWM_INT(pwm_int)
	);

	motor_stage_model stage_u (
		.clk(clk), .rst(rst), .upper(up), .lower(lo), .up_pol(up_pol),
		.lo_pol(lo_pol), .shoot_cnt(shoot), .last_gap(gap_u)
	);

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : print_verdict

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Ready is sampled mid-cycle so the registered slave outputs never race the bench
	task automatic bus(input logic [12:0] idx, input logic wr, input logic [31:0] wd);
		logic r;
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {17'h0, idx, 2'h0};
		hwrite <= wr;
		do begin
			@(negedge clk);
			r = hreadyout;
			@(posedge clk);
		end while (r !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do begin
			@(negedge clk);
			r = hreadyout;
			d = hrdata;
			@(posedge clk);
		end while (r !== 1'b1);
	endtask : bus

	task automatic ev_pulse(input int b);
		@(posedge clk);
		ev[b] <= 1'b1;
		repeat (4) @(posedge clk);
		ev[b] <= 1'b0;
	endtask : ev_pulse

	task automatic int_gap(output int n);
		n = 0;
		while (pwm_int !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		n = 1;
		while (pwm_int !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
	endtask : int_gap

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		void'($urandom(8));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check("upper_idle", {29'h0, up}, {29'h0, RST_OUT_IDLE});
		for (int i = 0; i < 4; i++) begin
			bus(ridx[i], 1'b0, 32'h0);
			check("reset_value", d, rexp[i]);
			check("hresp_okay", {31'h0, hresp}, 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			e = $urandom & 16'hffff;
			bus(IDX_MT_CMP1 + 13'(2 * i), 1'b1, 32'(e));
			bus(IDX_MT_CMP1 + 13'(2 * i), 1'b0, 32'h0);
			check("compare_rw", d, 32'(e));
		end
		bus(IDX_DEAD_TIME, 1'b1, 32'hff);
		bus(IDX_DEAD_TIME, 1'b0, 32'h0);
		check("dead_width", d, 32'h3f);
		bus(13'h1fa0, 1'b1, 32'h55);
		bus(13'h1fa0, 1'b0, 32'h0);
		check("unmapped", d, 32'h0);
		for (int i = 0; i < 5; i++) begin
			bus(IDX_MT_CTL_A, 1'b1, {24'h0, codes[i], 5'h01});
			bus(IDX_MT_CTL_A, 1'b1, {24'h0, codes[i], 5'h05});
			k = 300 + $urandom % 300;
			repeat (k) @(posedge clk);
			bus(IDX_MT_CTL_B, 1'b1, 32'h04);
			bus(IDX_MT_CAPTURE, 1'b0, 32'h0);
			e = (k + 3) / (8 << i);
			check("mt_count", 32'(int'(d) >= e - 2 && int'(d) <= e + 2), 32'h1);
		end
		bus(IDX_MT_CTL_A, 1'b0, 32'h0);
		check("swrst_reads0", d & 32'h4, 32'h0);
		// First a reserved clock code with the timer enabled, then the timer disabled
		for (int i = 0; i < 2; i++) begin
			bus(IDX_MT_CTL_A, 1'b1, (i == 0) ? 32'h61 : 32'h00);
			bus(IDX_MT_CTL_B, 1'b1, 32'h04);
			bus(IDX_MT_CAPTURE, 1'b0, 32'h0);
			d2 = d;
			repeat (300) @(posedge clk);
			bus(IDX_MT_CTL_B, 1'b1, 32'h04);
			bus(IDX_MT_CAPTURE, 1'b0, 32'h0);
			check("mt_stopped", d, d2);
		end
		for (int i = 0; i < 4; i++) begin
			bus(IDX_MT_CTL_A, 1'b1, {24'h0, ev_a[i]});
			bus(IDX_MT_CTL_B, 1'b1, {24'h0, ev_b[i]});
			bus(IDX_MT_CTL_A, 1'b1, {24'h0, ev_a[i] | 8'h04});
			repeat (400) @(posedge clk);
			ev_pulse(ev_n[i]);
			repeat (80) @(posedge clk);
			bus(IDX_MT_CAPTURE, 1'b0, 32'h0);
			check("ev_capture", 32'(d >= 46 && d <= 56), 32'(ev_b[i] != 0));
			bus(IDX_MT_CTL_B, 1'b1, {24'h0, ev_b[i] | 8'h04});
			bus(IDX_MT_CAPTURE, 1'b0, 32'h0);
			check("ev_clear", 32'(d < 20), 32'(i < 3));
		end
		bus(IDX_PATTERN, 1'b1, 32'h0009);
		for (int p = 0; p < 4; p++) begin
			bus(IDX_WAVE_CTL_A, 1'b1, 32'h01 | (32'(p) << 4));
			// Model polarity moves with the registered outputs, one edge after the write
			@(posedge clk);
			up_pol <= p[1];
			lo_pol <= p[0];
			repeat (4) @(negedge clk);
			check("upper_static", {29'h0, up}, p[1] ? 32'h1 : 32'h6);
			check("lower_static", {29'h0, lo}, p[0] ? 32'h2 : 32'h5);
		end
		bus(IDX_WAVE_CTL_A, 1'b1, 32'h30);
		repeat (4) @(negedge clk);
		check("upper_off", {26'h0, up, lo}, 32'h0);
		bus(IDX_WAVE_CTL_A, 1'b1, 32'h31);
		for (int s = 1; s < 4; s++) begin
			bus(IDX_PATTERN, 1'b1, (32'(s) << 6) | (32'h1 << (2 * (s % 3))));
			repeat (10) @(negedge clk);
			check("sync_hold", {29'h0, up}, 32'h1 << (s - 1));
			ev_pulse(s == 1 ? EV_POS : (s == 2 ? EV_T1 : EV_T2));
			repeat (8) @(negedge clk);
			check("sync_apply", {29'h0, up}, 32'h1 << (s % 3));
		end
		bus(IDX_PWM_PERIOD, 1'b1, 32'h010);
		bus(IDX_CMP_U, 1'b1, 32'h008);
		for (int c = 0; c < 4; c++) begin
			bus(IDX_WAVE_CTL_B, 1'b1, 32'(c));
			int_gap(g);
			int_gap(g);
			check("pwm_clock", 32'(g), 32'(32 << c));
		end
		bus(IDX_WAVE_CTL_B, 1'b1, 32'h0);
		for (int m = 0; m < 8; m++) begin
			bus(IDX_WAVE_CTL_A, 1'b1, {24'h0, md_a[m]});
			int_gap(g);
			int_gap(g);
			check("int_spacing", 32'(g), 32'(md_g[m]));
		end
		// Period-synchronised pattern: written just after a period end, held a whole period
		bus(IDX_WAVE_CTL_B, 1'b1, 32'h3);
		while (pwm_int !== 1'b1)
			@(negedge clk);
		bus(IDX_PATTERN, 1'b1, 32'h0804);
		repeat (10) @(negedge clk);
		check("pwm_sync_hold", {29'h0, up}, 32'h1);
		repeat (300) @(negedge clk);
		check("pwm_sync_apply", {29'h0, up}, 32'h2);
		dtv = 1 + $urandom % 5;
		bus(IDX_DEAD_TIME, 1'b1, 32'(dtv));
		bus(IDX_WAVE_CTL_B, 1'b1, 32'h3);
		bus(IDX_PATTERN, 1'b1, 32'h0103);
		ev_pulse(EV_T2);
		bus(IDX_WAVE_CTL_A, 1'b1, 32'h31);
		repeat (600) @(negedge clk);
		check("dead_gap", 32'(gap_u >= dtv * 8 - 1 && gap_u <= dtv * 8 + 1), 32'h1);
		check("shoot_through", 32'(shoot), 32'h0);
		// U duty never on, V duty always on: V follows U unless per-phase duty is set
		bus(IDX_CMP_U, 1'b1, 32'h000);
		bus(IDX_CMP_V, 1'b1, 32'h010);
		bus(IDX_PATTERN, 1'b1, 32'h020c);
		for (int m = 0; m < 2; m++) begin
			bus(IDX_WAVE_CTL_A, 1'b1, (m == 1) ? 32'h71 : 32'h31);
			repeat (100) @(negedge clk);
			check("duty_select", {26'h0, up, lo}, (m == 1) ? 32'h10 : 32'h02);
		end
		check("shoot_late", 32'(shoot), 32'h0);
		print_verdict();
	end
endmodule : motor_mode_timer_pwm_waveform_tb
